// ===== src/adc_ctrl_pkg.sv
// constants, register map and timing of the converter control block
// assumes a single 20 MHz system clock and an AHB-Lite register slave
package adc_ctrl_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  RESULT_IDX      = 8'h70;
    localparam logic [7:0]  CTRL_IDX        = 8'h71;
    localparam logic [7:0]  IRQ_STATUS_IDX  = 8'h72;
    localparam logic [7:0]  IRQ_MASK_IDX    = 8'h73;
    localparam logic [9:0]  RESULT_ADDR     = {RESULT_IDX, 2'b00};
    localparam logic [9:0]  CTRL_ADDR       = {CTRL_IDX, 2'b00};
    localparam logic [9:0]  IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'b00};
    localparam logic [9:0]  IRQ_MASK_ADDR   = {IRQ_MASK_IDX, 2'b00};
    // ----------------------------------------------------------------
    // control/status fields and reset values
    // ----------------------------------------------------------------
    localparam int          DONE_BIT        = 7;
    localparam int          ON_BIT          = 5;
    localparam int          CH_LSB          = 0;
    localparam int          CH_W            = 4;
    localparam int          NUM_CH          = 16;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [7:0]  RESULT_RESET    = 8'h00;
    localparam int          IRQ_W           = 2;
    localparam int          IRQ_DONE_BIT    = 0;
    localparam int          IRQ_ABORT_BIT   = 1;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLK_HZ          = 20_000_000;
    localparam int          ADC_DIV         = 2;
    localparam int          CONV_ADC_CLKS   = 12;
    localparam int          SAR_STEPS       = 8;
    localparam int          LOAD_ADC_CLKS   = CONV_ADC_CLKS - SAR_STEPS;
    localparam int          CONV_SYS_CLKS   = CONV_ADC_CLKS * ADC_DIV;
    localparam int          LOAD_SYS_CLKS   = LOAD_ADC_CLKS * ADC_DIV;
    localparam logic [4:0]  CONV_LAST       = 5'(CONV_SYS_CLKS - 1);
    localparam logic [4:0]  LOAD_LAST       = 5'(LOAD_SYS_CLKS - 1);
    localparam int          STABLE_NS       = 1000;
    localparam logic [4:0]  STABLE_CLKS     = 5'((STABLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000);

    typedef enum logic [1:0] {
        ST_OFF,
        ST_SETTLE,
        ST_LOAD,
        ST_SAR
    } conv_state_t;
endpackage

// ===== src/sar_engine.sv
// successive-approximation bit engine driven by converter clock ticks
// assumes the comparator answer is valid on the tick that samples it
`timescale 1ns/10ps
module sar_engine
    import adc_ctrl_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       start_i,
    input  wire logic       step_i,
    input  wire logic       comp_high_i,
    output logic [7:0]      trial_o,
    output logic [7:0]      value_o
);
    logic [7:0] trial;
    logic [7:0] value;
    logic [7:0] next_trial;
    logic [7:0] next_value;

    // ----------------------------------------------------------------
    // one bit decided per step, msb first
    // ----------------------------------------------------------------
    always_comb begin
        next_trial = trial;
        next_value = value;
        if (start_i) begin
            next_trial = 8'h80;
            next_value = 8'h00;
        end else if (step_i && (trial != 8'h00)) begin
            if (comp_high_i) begin
                next_value = value | trial;
            end
            next_trial = trial >> 1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trial <= 8'h00;
            value <= 8'h00;
        end else begin
            trial <= next_trial;
            value <= next_value;
        end
    end

    // the dac needs the whole code under test, not only the trial bit
    assign trial_o = value | trial;
    // last bit is decided on the closing edge, so hand over the next value
    assign value_o = next_value;
endmodule // sar_engine

// ===== src/adc_ctrl.sv
// converter control, status and result registers behind an AHB-Lite slave
// assumes a single-word master; comparator core and pads sit outside
`timescale 1ns/10ps
module adc_ctrl
    import adc_ctrl_pkg::*;
(
    input  wire logic                 sys_clk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 hsel_i,
    input  wire logic [31:0]          haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic [31:0]               hrdata_o,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    input  wire logic                 halt_i,
    input  wire logic                 comp_high_i,
    input  wire logic [NUM_CH-1:0]    pin_level_i,
    output logic [CH_W-1:0]           channel_select_o,
    output logic [NUM_CH-1:0]         analog_input_n_o,
    output logic                      converter_power_o,
    output logic                      sample_o,
    output logic [7:0]                dac_trial_o,
    output logic [NUM_CH-1:0]         pin_level_o,
    output logic                      irq_o
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    // only the second flop is read, so release never races the clock
    assign rst_n = rst_sync[1];

    // ----------------------------------------------------------------
    // bus address phase capture
    // ----------------------------------------------------------------
    logic       dp_wr;
    logic       dp_rd;
    logic [9:0] dp_addr;
    logic       next_dp_wr;
    logic       next_dp_rd;
    logic [9:0] next_dp_addr;
    logic       take;

    // hsize is not decoded: every register is one aligned word
    always_comb begin
        take         = hsel_i && hready_i && htrans_i[1];
        next_dp_wr   = take && hwrite_i;
        next_dp_rd   = take && !hwrite_i;
        next_dp_addr = take ? haddr_i[9:0] : dp_addr;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dp_wr   <= 1'b0;
            dp_rd   <= 1'b0;
            dp_addr <= 10'h000;
        end else begin
            dp_wr   <= next_dp_wr;
            dp_rd   <= next_dp_rd;
            dp_addr <= next_dp_addr;
        end
    end

    logic ctrl_wr;
    logic result_rd;
    logic status_wr;
    logic mask_wr;
    assign ctrl_wr   = dp_wr && (dp_addr == CTRL_ADDR);
    assign status_wr = dp_wr && (dp_addr == IRQ_STATUS_ADDR);
    assign mask_wr   = dp_wr && (dp_addr == IRQ_MASK_ADDR);
    assign result_rd = dp_rd && (dp_addr == RESULT_ADDR);

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    conv_state_t state;
    conv_state_t next_state;
    logic [4:0]  cnt;
    logic [4:0]  next_cnt;
    logic        on_bit;
    logic        next_on;
    logic [3:0]  chan;
    logic [3:0]  next_chan;
    logic        done;
    logic        next_done;
    logic [7:0]  result;
    logic [7:0]  next_result;
    logic        halted;
    logic        sar_start;
    logic        sar_step;
    logic        conv_end;
    logic        abort;
    logic [7:0]  sar_trial;
    logic [7:0]  sar_value;

    always_comb begin
        next_state  = state;
        next_cnt    = cnt + 5'd1;
        next_on     = on_bit;
        next_chan   = chan;
        next_done   = done;
        next_result = result;
        sar_start   = 1'b0;
        sar_step    = 1'b0;
        conv_end    = 1'b0;
        abort       = 1'b0;
        // register writes; reserved bits 6 and 4 are simply not stored
        if (ctrl_wr) begin
            next_on   = hwdata_i[ON_BIT];
            next_chan = hwdata_i[CH_LSB +: CH_W];
        end
        // halt powers the core down; wait mode has no input so it runs on
        halted = halt_i;
        case (state)
            ST_OFF: begin
                next_cnt = 5'd0;
                if (on_bit && !halted) begin
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // analog settling after power-up or halt wakeup
                if (cnt == STABLE_CLKS - 5'd1) begin
                    next_state = ST_LOAD;
                    next_cnt   = 5'd0;
                end
            end
            ST_LOAD: begin
                if (cnt == LOAD_LAST) begin
                    next_state = ST_SAR;
                    sar_start  = 1'b1;
                end
            end
            ST_SAR: begin
                // one approximation step per converter clock, i.e. every 2nd edge
                sar_step = cnt[0];
                if (cnt == CONV_LAST) begin
                    conv_end    = 1'b1;
                    next_result = sar_value;
                    next_state  = ST_LOAD;
                    next_cnt    = 5'd0;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        // abort and restart; an ending conversion in that cycle is dropped
        if (ctrl_wr && hwdata_i[ON_BIT] && (state == ST_LOAD || state == ST_SAR)) begin
            abort       = conv_end || (state == ST_SAR) || (cnt != 5'd0);
            next_state  = ST_LOAD;
            next_cnt    = 5'd0;
            next_result = result;
            conv_end    = 1'b0;
        end
        if (!next_on || halted) begin
            next_state = ST_OFF;
            next_cnt   = 5'd0;
            conv_end   = 1'b0;
            next_result = result;
        end
        // flag set together with result; a result read or a control write clears it
        if (conv_end) begin
            next_done = 1'b1;
        end else if (result_rd || ctrl_wr) begin
            next_done = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state  <= ST_OFF;
            cnt    <= 5'd0;
            on_bit <= CTRL_RESET[ON_BIT];
            chan   <= CTRL_RESET[CH_LSB +: CH_W];
            done   <= CTRL_RESET[DONE_BIT];
            result <= RESULT_RESET;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            on_bit <= next_on;
            chan   <= next_chan;
            done   <= next_done;
            result <= next_result;
        end
    end

    // ----------------------------------------------------------------
    // approximation engine
    // ----------------------------------------------------------------
    // trial code leaves registered, so the comparator answers a cycle later
    sar_engine sar_engine_inst (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n),
        .start_i     (sar_start),
        .step_i      (sar_step),
        .comp_high_i (comp_high_i),
        .trial_o     (sar_trial),
        .value_o     (sar_value)
    );

    // ----------------------------------------------------------------
    // interrupt status and mask (done events, aborted conversions)
    // ----------------------------------------------------------------
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] next_irq_mask;
    logic [IRQ_W-1:0] irq_evt;

    always_comb begin
        irq_evt                = '0;
        irq_evt[IRQ_DONE_BIT]  = conv_end;
        irq_evt[IRQ_ABORT_BIT] = abort;
        next_irq_mask = mask_wr ? hwdata_i[IRQ_W-1:0] : irq_mask;
        // a new event wins over a clear in the same cycle
        next_irq_stat = irq_stat;
        if (status_wr) begin
            next_irq_stat = irq_stat & ~hwdata_i[IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | irq_evt;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    logic [31:0]       rdata;
    logic [31:0]       next_rdata;
    logic [NUM_CH-1:0] next_sel_onehot;
    logic              next_irq;

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (next_dp_rd) begin
            case (haddr_i[9:0])
                RESULT_ADDR:     next_rdata[7:0] = next_result;
                CTRL_ADDR: begin
                    next_rdata[DONE_BIT]           = next_done;
                    next_rdata[ON_BIT]             = next_on;
                    next_rdata[CH_LSB +: CH_W]     = next_chan;
                end
                IRQ_STATUS_ADDR: next_rdata[IRQ_W-1:0] = next_irq_stat;
                IRQ_MASK_ADDR:   next_rdata[IRQ_W-1:0] = next_irq_mask;
                default:         next_rdata = 32'h0000_0000;
            endcase
        end
        next_sel_onehot = '0;
        next_sel_onehot[next_chan] = (next_state != ST_OFF);
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata             <= 32'h0000_0000;
            channel_select_o  <= '0;
            analog_input_n_o  <= '0;
            converter_power_o <= 1'b0;
            sample_o          <= 1'b0;
            dac_trial_o       <= 8'h00;
            pin_level_o       <= '0;
            irq_o             <= 1'b0;
        end else begin
            rdata             <= next_rdata;
            channel_select_o  <= next_chan;
            analog_input_n_o  <= next_sel_onehot;
            converter_power_o <= (next_state != ST_OFF);
            sample_o          <= (next_state == ST_LOAD);
            dac_trial_o       <= sar_trial;
            pin_level_o       <= pin_level_i;
            irq_o             <= next_irq;
        end
    end

    // ----------------------------------------------------------------
    // bus response: zero wait states, never an error
    // ----------------------------------------------------------------
    assign hrdata_o    = rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
endmodule // adc_ctrl

// ===== verif/adc_ctrl_asserts.sv
// port-level checks for the converter control block
// assumes zero-wait single-word bus transfers and the package register map
`timescale 1ns/10ps
module adc_ctrl_asserts
    import adc_ctrl_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              resetn_i,
    input  wire logic              hsel_i,
    input  wire logic [31:0]       haddr_i,
    input  wire logic [1:0]        htrans_i,
    input  wire logic              hwrite_i,
    input  wire logic [31:0]       hwdata_i,
    input  wire logic              hready_i,
    input  wire logic [31:0]       hrdata_o,
    input  wire logic              halt_i,
    input  wire logic [NUM_CH-1:0] pin_level_i,
    input  wire logic [NUM_CH-1:0] pin_level_o,
    input  wire logic [CH_W-1:0]   channel_select_o,
    input  wire logic [NUM_CH-1:0] analog_input_n_o,
    input  wire logic              converter_power_o,
    input  wire logic              sample_o
);
    // --------------------------------------------------------------
    // data-phase tracking
    // --------------------------------------------------------------
    logic       take;
    logic       rd_any;
    logic       rd_ctrl;
    logic       wr_ctrl;
    logic [2:0] up;
    assign take = hsel_i && hready_i && htrans_i[1];
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_any  <= 1'b0;
            rd_ctrl <= 1'b0;
            wr_ctrl <= 1'b0;
            up      <= 3'd0;
        end else begin
            rd_any  <= take && !hwrite_i;
            rd_ctrl <= take && !hwrite_i && haddr_i[9:0] == CTRL_ADDR;
            wr_ctrl <= take && hwrite_i && haddr_i[9:0] == CTRL_ADDR;
            // reset sync keeps outputs low a few edges after release
            up      <= (up == 3'd4) ? up : up + 3'd1;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    AST_READ_WIDTH: assert property (rd_any |-> hrdata_o[31:8] == 24'h0)
        else $error("read data wider than eight bits");
    AST_CTRL_RSVD: assert property (rd_ctrl |-> !hrdata_o[6] && !hrdata_o[4])
        else $error("reserved control bits read non-zero");
    AST_OFF_AFTER_WRITE: assert property (
        wr_ctrl && !hwdata_i[ON_BIT] |-> ##[1:3] !converter_power_o)
        else $error("converter stayed powered after switch-off");
    AST_ON_AFTER_WRITE: assert property (
        wr_ctrl && hwdata_i[ON_BIT] && !halt_i |-> ##[1:3] converter_power_o)
        else $error("converter not powered after switch-on");
    AST_HALT_OFF: assert property (halt_i [*3] |-> !converter_power_o)
        else $error("converter powered in halt");
    AST_OFF_NO_INPUT: assert property (
        !converter_power_o [*2] |-> analog_input_n_o == 16'h0)
        else $error("input routed while off");
    AST_ONE_HOT: assert property (
        converter_power_o && $past(converter_power_o) && $stable(channel_select_o)
        |-> analog_input_n_o == 16'h1 << channel_select_o)
        else $error("selected input does not match channel field");
    AST_LOAD_LEN: assert property (
        $rose(sample_o) ##0 (!wr_ctrl && !halt_i) [*8] |-> sample_o)
        else $error("load phase shorter than four converter clocks");
    AST_SETTLE_LOAD: assert property (
        $rose(converter_power_o) |-> !sample_o [*8] ##[1:30] sample_o)
        else $error("load did not follow power-up settling");
    AST_PIN_PASS: assert property (up == 3'd4 |=> pin_level_o == $past(pin_level_i))
        else $error("digital pin level lost");
    cover property ($rose(sample_o));
    cover property (wr_ctrl && hwdata_i[ON_BIT]);
    cover property (halt_i && $fell(converter_power_o));
endmodule // adc_ctrl_asserts

bind adc_ctrl adc_ctrl_asserts adc_ctrl_asserts_inst (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .halt_i(halt_i), .pin_level_i(pin_level_i),
    .pin_level_o(pin_level_o), .channel_select_o(channel_select_o),
    .analog_input_n_o(analog_input_n_o), .converter_power_o(converter_power_o),
    .sample_o(sample_o)
);

// ===== verif/sar_core_model.sv
// comparator and input pins standing behind the converter control block
// assumes one-hot input selection and a live trial code from the block
`timescale 1ns/10ps
module sar_core_model (
    input  wire logic        sys_clk_i,
    input  wire logic [15:0] analog_input_n_i,
    input  wire logic        power_i,
    input  wire logic [7:0]  dac_trial_i,
    output logic             comp_high_o
);
    // channel n sits at 11h times n, so channels 0 and 15 hit both ends
    logic [7:0] level;
    logic       noise = 1'b0;
    always_ff @(posedge sys_clk_i) noise <= ~noise;
    always_comb begin
        level = 8'h00;
        for (int n = 0; n < 16; n++)
            if (analog_input_n_i[n]) level = 8'(8'h11 * n);
        // unpowered or unselected the answer is meaningless, so it wanders
        comp_high_o = (power_i && analog_input_n_i != 16'h0) ? (level >= dac_trial_i) : noise;
    end
endmodule // sar_core_model

// ===== verif/sar_adc_control_tb.sv
// self-checking bench for the converter control block
// assumes the comparator model and a zero-wait register slave
`timescale 1ns/10ps
module sar_adc_control_tb;
    import adc_ctrl_pkg::*;
    logic        sys_clk_i, resetn_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
    logic        halt_i, comp_high_i, converter_power_o, sample_o, irq_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, q;
    logic [1:0]  htrans_i;
    logic [2:0]  hsize_i;
    logic [15:0] pin_level_i, pin_level_o, analog_input_n_o;
    logic [3:0]  channel_select_o;
    logic [7:0]  dac_trial_o;
    logic        p;
    int          bad_count, tests_run, t0, hits;
    assign hready_i = hreadyout_o;
    adc_ctrl adc_ctrl_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .halt_i(halt_i),
        .comp_high_i(comp_high_i), .pin_level_i(pin_level_i),
        .channel_select_o(channel_select_o), .analog_input_n_o(analog_input_n_o),
        .converter_power_o(converter_power_o), .sample_o(sample_o),
        .dac_trial_o(dac_trial_o), .pin_level_o(pin_level_o), .irq_o(irq_o));
    sar_core_model sar_core_model_inst (.sys_clk_i(sys_clk_i), .analog_input_n_i(analog_input_n_o),
        .power_i(converter_power_o), .dac_trial_i(dac_trial_o), .comp_high_o(comp_high_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // --------------------------------------------------------------
    // bus and check tasks
    // --------------------------------------------------------------
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdy();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 64);
        if (hreadyout_o !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t ns: bus hung", $time);
            results();
        end
    endtask
    task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
        hsel_i   <= 1'b1;
        haddr_i  <= {22'h0, a};
        hwrite_i <= w;
        htrans_i <= 2'h2;
        rdy();
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= {24'h0, d};
        rdy();
        q = hrdata_o;
        // let write effects and registered flags land before the next look
        repeat (2) @(posedge sys_clk_i);
    endtask
    task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    task automatic wait_done();
        for (int k = 0; k < 40; k++) begin
            xfer(1'b0, CTRL_ADDR, 8'h00);
            if (q[DONE_BIT] === 1'b1) return;
        end
        bad_count++;
        $display("unexpected at %0t ns: no conversion finished", $time);
        results();
    endtask
    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        {resetn_i, hsel_i, hwrite_i, halt_i, htrans_i, haddr_i, hwdata_i} = '0;
        hsize_i = 3'h2;
        pin_level_i = 16'ha5c3;
        bad_count = 0;
        tests_run = 0;
        repeat (16) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rdc(CTRL_ADDR, 32'h0);
        xfer(1'b1, RESULT_ADDR, 8'h5a);
        rdc(RESULT_ADDR, 32'h0);
        rdc(10'h1d0, 32'h0);
        chk(pin_level_o, 32'ha5c3);
        chk(hresp_o, 1'b0);
        chk(hreadyout_o, 1'b1);
        chk(dac_trial_o, 32'h0);
        $display("test reset and map done");
        for (int ch = 0; ch < NUM_CH; ch++) begin
            xfer(1'b1, CTRL_ADDR, 8'h20 | 8'(ch));
            wait_done();
            xfer(1'b1, CTRL_ADDR, 8'h20 | 8'(ch));
            rdc(CTRL_ADDR, 32'h20 | ch);
            wait_done();
            rdc(RESULT_ADDR, 32'h11 * ch);
            rdc(CTRL_ADDR, 32'h20 | ch);
            chk(analog_input_n_o, 32'(16'h1 << ch));
            chk(channel_select_o, 32'(ch));
        end
        $display("test channel sweep done");
        rdc(IRQ_STATUS_ADDR, 32'h3);
        chk(irq_o, 1'b0);
        xfer(1'b1, IRQ_MASK_ADDR, 8'h01);
        chk(irq_o, 1'b1);
        xfer(1'b1, IRQ_MASK_ADDR, 8'h00);
        chk(irq_o, 1'b0);
        xfer(1'b1, IRQ_MASK_ADDR, 8'h01);
        xfer(1'b1, CTRL_ADDR, 8'h0f);
        repeat (60) @(posedge sys_clk_i);
        chk(converter_power_o, 1'b0);
        rdc(CTRL_ADDR, 32'h0f);
        xfer(1'b1, IRQ_STATUS_ADDR, 8'h03);
        rdc(IRQ_STATUS_ADDR, 32'h0);
        chk(irq_o, 1'b0);
        $display("test interrupt and off done");
        xfer(1'b1, CTRL_ADDR, 8'h23);
        wait_done();
        halt_i <= 1'b1;
        rdc(RESULT_ADDR, 32'h33);
        repeat (60) @(posedge sys_clk_i);
        chk(converter_power_o, 1'b0);
        rdc(CTRL_ADDR, 32'h23);
        halt_i <= 1'b0;
        t0 = 0;
        hits = 0;
        p = 1'b1;
        for (int k = 0; k < 120 && hits < 2; k++) begin
            @(posedge sys_clk_i);
            if (sample_o === 1'b1 && p === 1'b0) begin
                hits++;
                t0 = k - t0;
            end
            p = sample_o;
        end
        chk(t0, 32'(CONV_SYS_CLKS));
        wait_done();
        rdc(RESULT_ADDR, 32'h33);
        $display("test halt and timing done");
        results();
    end
endmodule // sar_adc_control_tb
